// ---- hdl/wdt_top.sv ----
// Functional notes
// - Watchdog runs only while disable fuse is 0
// - Scheme fuse: 0 simple seed, 1 challenger
// - Finite window is CLOSED part then OPEN part
// - Wrong answer in OPEN is bad refresh
// - OPEN expiring without refresh is bad refresh
// - Any answer in CLOSED is bad refresh
// - Every judged refresh restarts window, CLOSED first unless infinite
// - Timing errors set timing fault flag
// - Wrong answer value sets answer fault flag
// - Period code picks 1 to 1024 ms, reset 0011
// - Code 0000 means infinite, init phase only
// - New period applies after next refresh
// - Period applies only with complementary inverse field
// - First window after start lasts 1024 ms
// - Duty code sets CLOSED/OPEN split
// - New duty applies after next refresh
// - Simple answer equals seed, default 5AB2
// - Challenger LFSR advances only on good answer
// - Error counter +2 bad, -1 good, clears at limit
`include "wdt_defs.svh"
`default_nettype none
module wdt_top
   import wdt_pkg::*;
#(
   parameter int MS_CYCLES = `WDT_MS_NS / `WDT_CLK_PERIOD_NS
) (
   input  wire logic         CLK_SYS,
   input  wire logic         ARST_N,
   input  wire logic         WDOG_DISABLE_FUSE,
   input  wire logic         SCHEME_SELECT_FUSE,
   input  wire logic         INIT_PHASE,
   input  wire logic         CFG_WR,
   input  wire logic [3:0]   CFG_PERIOD_CODE,
   input  wire logic [3:0]   CFG_PERIOD_INV,
   input  wire logic [2:0]   CFG_DUTY_CODE,
   input  wire logic         SEED_WR,
   input  wire logic [15:0]  SEED_DATA,
   input  wire logic         ANSWER_WR,
   input  wire logic [15:0]  ANSWER_DATA,
   input  wire logic         FLAG_CLR_TIMING,
   input  wire logic         FLAG_CLR_ANSWER,
   output logic [3:0]        WINDOW_PERIOD_CODE,
   output logic [3:0]        WINDOW_PERIOD_INVERSE,
   output logic [2:0]        WINDOW_DUTY_CODE,
   output logic [15:0]       SEED_VALUE,
   output logic [3:0]        ERR_COUNT,
   output logic              TIMING_FAULT_FLAG,
   output logic              ANSWER_FAULT_FLAG,
   output logic              WDOG_ACTIVE,
   output logic              WINDOW_OPEN,
   output logic              GOOD_REFRESH,
   output logic              BAD_REFRESH,
   output logic              SEED_REJECT,
   output logic              WDOG_FAIL
);
   localparam int TICK_CYCLES = MS_CYCLES / `WDT_SUBTICKS;

   ////////////////////////////////////////////////////////////////////////
   // Decoders
   function automatic wdt_len_type period_sub(input wdt_period_type code);
      logic [10:0] ms;
      ms = 11'h000;
      unique case (code)
         4'h0: ms = 11'h000;
         4'h1: ms = 11'h001;
         4'h2: ms = 11'h002;
         4'h3: ms = 11'h003;
         4'h4: ms = 11'h004;
         4'h5: ms = 11'h006;
         4'h6: ms = 11'h008;
         4'h7: ms = 11'h00C;
         4'h8: ms = 11'h010;
         4'h9: ms = 11'h018;
         4'hA: ms = 11'h020;
         4'hB: ms = 11'h040;
         4'hC: ms = 11'h080;
         4'hD: ms = 11'h100;
         4'hE: ms = 11'h200;
         4'hF: ms = 11'h400;
      endcase
      return {ms, 4'h0};
   endfunction

   // Closed share in sixteenths of the period
   function automatic logic [3:0] duty_closed(input wdt_duty_type code);
      logic [3:0] d;
      d = 4'h8;
      unique case (code)
         3'h0:    d = 4'h5;
         3'h1:    d = 4'h6;
         3'h3:    d = 4'hA;
         3'h4:    d = 4'hB;
         default: d = 4'h8;
      endcase
      return d;
   endfunction

   function automatic wdt_len_type closed_of(input wdt_len_type len, input wdt_duty_type dc);
      logic [18:0] prod;
      prod = 19'(len) * 19'(duty_closed(dc));
      return prod[18:4];
   endfunction

   function automatic wdt_word_type lfsr_step(input wdt_word_type v);
      return {v[14:0], ^(v & `WDT_LFSR_TAPS)};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Fuse synchronisers
   logic [1:0] fuse_s1_q, fuse_s2_q;
   logic       fuse_dis;
   logic       chall;

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         fuse_s1_q <= 2'h1;
         fuse_s2_q <= 2'h1;
      end else begin
         fuse_s1_q <= {SCHEME_SELECT_FUSE, WDOG_DISABLE_FUSE};
         fuse_s2_q <= fuse_s1_q;
      end
   end

   assign fuse_dis = fuse_s2_q[0];
   assign chall    = fuse_s2_q[1];

   ////////////////////////////////////////////////////////////////////////
   // Window timer
   wdt_tmr_if tif ();

   wdt_window_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .clk    (CLK_SYS),
      .arst_n (ARST_N),
      .tif    (tif.tmr)
   );

   ////////////////////////////////////////////////////////////////////////
   // Judgement and window sequencing
   wdt_phase_type  phase_q, phase_d;
   wdt_period_type period_act_q, period_act_d;
   wdt_duty_type   duty_act_q, duty_act_d;
   logic           ans_wr;
   logic           closed_now;
   logic           match;
   logic           timing_bad;
   logic           data_bad;
   logic           good;
   logic           judged;
   wdt_len_type    cur_len;
   wdt_word_type   seed_q, seed_d;
   wdt_period_type period_code_q, period_code_d;
   wdt_period_type period_inv_q, period_inv_d;
   wdt_duty_type   duty_code_q, duty_code_d;

   always_comb begin
      ans_wr     = ANSWER_WR && (phase_q != WDT_OFF);
      closed_now = !tif.in_open;
      match      = (ANSWER_DATA == seed_q);
      timing_bad = (tif.timeout && !ans_wr && (phase_q != WDT_OFF)) ||
                   (ans_wr && closed_now);
      data_bad   = ans_wr && !closed_now && !match;
      good       = ans_wr && !closed_now && match;
      judged     = timing_bad || data_bad || good;
      phase_d      = phase_q;
      period_act_d = period_act_q;
      duty_act_d   = duty_act_q;
      unique case (phase_q)
         WDT_OFF: begin
            if (!fuse_dis) begin
               phase_d = WDT_FIRST;
            end
         end
         WDT_FIRST: begin
            if (judged) begin
               phase_d = WDT_RUN;
            end
         end
         WDT_RUN: begin
         end
      endcase
      // Pending settings are only adopted at a refresh boundary
      if (judged) begin
         duty_act_d = duty_code_q;
         if ((period_code_q == ~period_inv_q) &&
             ((period_code_q != `WDT_PERIOD_OFF) || INIT_PHASE)) begin
            period_act_d = period_code_q;
         end
      end
      if (fuse_dis) begin
         phase_d = WDT_OFF;
      end
      cur_len = (phase_q == WDT_FIRST) ? period_sub(`WDT_PERIOD_FIRST)
                                       : period_sub(period_act_q);
      tif.restart    = (phase_q == WDT_OFF) || judged;
      tif.infinite   = (phase_q == WDT_RUN) && (period_act_q == `WDT_PERIOD_OFF);
      tif.period_len = cur_len;
      tif.closed_len = closed_of(cur_len, duty_act_q);
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         phase_q      <= WDT_OFF;
         period_act_q <= `WDT_PERIOD_RST;
         duty_act_q   <= `WDT_DUTY_RST;
      end else begin
         phase_q      <= phase_d;
         period_act_q <= period_act_d;
         duty_act_q   <= duty_act_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Written configuration and seed
   logic seed_ok;
   logic seed_rej;

   always_comb begin
      period_code_d = period_code_q;
      period_inv_d  = period_inv_q;
      duty_code_d   = duty_code_q;
      if (CFG_WR) begin
         period_code_d = CFG_PERIOD_CODE;
         period_inv_d  = CFG_PERIOD_INV;
         duty_code_d   = CFG_DUTY_CODE;
      end
      // Challenger seeds are taken only during init
      if (chall) begin
         seed_ok = (SEED_DATA != `WDT_SEED_ZERO) && INIT_PHASE;
      end else begin
         seed_ok = (SEED_DATA != `WDT_SEED_ZERO) && (SEED_DATA != `WDT_SEED_ONES);
      end
      seed_rej = SEED_WR && !seed_ok;
      seed_d   = seed_q;
      if (good && chall) begin
         seed_d = lfsr_step(seed_q);
      end
      // Host seed overrides an advance in the same cycle
      if (SEED_WR && seed_ok) begin
         seed_d = SEED_DATA;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         period_code_q <= `WDT_PERIOD_RST;
         period_inv_q  <= `WDT_PERIOD_INV_RST;
         duty_code_q   <= `WDT_DUTY_RST;
         seed_q        <= `WDT_SEED_RST;
      end else begin
         period_code_q <= period_code_d;
         period_inv_q  <= period_inv_d;
         duty_code_q   <= duty_code_d;
         seed_q        <= seed_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Error counter and diagnostic flags
   logic [4:0] err_q, err_d;
   logic [4:0] err_sum;
   logic       fail;
   logic       tflag_q, tflag_d;
   logic       aflag_q, aflag_d;

   always_comb begin
      err_sum = err_q + `WDT_ERR_BAD_STEP;
      err_d   = err_q;
      fail    = 1'b0;
      if (timing_bad || data_bad) begin
         if (err_sum >= `WDT_ERR_LIMIT) begin
            err_d = 5'h00;
            fail  = 1'b1;
         end else begin
            err_d = err_sum;
         end
      end else if (good && (err_q != 5'h00)) begin
         err_d = err_q - `WDT_ERR_GOOD_STEP;
      end
      // Set wins over a clear in the same cycle
      tflag_d = (tflag_q && !FLAG_CLR_TIMING) || timing_bad;
      aflag_d = (aflag_q && !FLAG_CLR_ANSWER) || data_bad;
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         err_q   <= 5'h00;
         tflag_q <= 1'b0;
         aflag_q <= 1'b0;
      end else begin
         err_q   <= err_d;
         tflag_q <= tflag_d;
         aflag_q <= aflag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered event outputs
   logic good_q, bad_q, rej_q, fail_q, open_q;

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         good_q <= 1'b0;
         bad_q  <= 1'b0;
         rej_q  <= 1'b0;
         fail_q <= 1'b0;
         open_q <= 1'b0;
      end else begin
         good_q <= good;
         bad_q  <= timing_bad || data_bad;
         rej_q  <= seed_rej;
         fail_q <= fail;
         open_q <= (phase_q != WDT_OFF) && tif.in_open && !tif.restart;
      end
   end

   assign WINDOW_PERIOD_CODE    = period_code_q;
   assign WINDOW_PERIOD_INVERSE = period_inv_q;
   assign WINDOW_DUTY_CODE      = duty_code_q;
   assign SEED_VALUE            = seed_q;
   assign ERR_COUNT             = err_q[3:0];
   assign TIMING_FAULT_FLAG     = tflag_q;
   assign ANSWER_FAULT_FLAG     = aflag_q;
   assign WDOG_ACTIVE           = (phase_q != WDT_OFF);
   assign WINDOW_OPEN           = open_q;
   assign GOOD_REFRESH          = good_q;
   assign BAD_REFRESH           = bad_q;
   assign SEED_REJECT           = rej_q;
   assign WDOG_FAIL             = fail_q;
endmodule // wdt_top
`default_nettype wire

// ---- pkg/wdt_defs.svh ----
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
// Timing
`define WDT_CLK_PERIOD_NS 40
`define WDT_MS_NS         1000000
`define WDT_SUBTICKS      16
// Period and duty codes
`define WDT_PERIOD_RST    4'h3
`define WDT_PERIOD_OFF    4'h0
`define WDT_PERIOD_FIRST  4'hF
`define WDT_PERIOD_INV_RST 4'hC
`define WDT_DUTY_RST      3'h2
// Seed and challenger
`define WDT_SEED_RST      16'h5AB2
`define WDT_SEED_ZERO     16'h0000
`define WDT_SEED_ONES     16'hFFFF
`define WDT_LFSR_TAPS     16'hB400
// Error counter
`define WDT_ERR_LIMIT     5'h08
`define WDT_ERR_BAD_STEP  5'h02
`define WDT_ERR_GOOD_STEP 5'h01
`endif

// ---- pkg/wdt_pkg.sv ----
`default_nettype none
package wdt_pkg;
   typedef enum logic [1:0] {WDT_OFF, WDT_FIRST, WDT_RUN} wdt_phase_type;
   typedef logic [14:0] wdt_len_type;
   typedef logic [3:0]  wdt_period_type;
   typedef logic [2:0]  wdt_duty_type;
   typedef logic [15:0] wdt_word_type;
endpackage
`default_nettype wire

// ---- pkg/wdt_tmr_if.sv ----
`default_nettype none
interface wdt_tmr_if;
   import wdt_pkg::*;
   logic        restart;
   logic        infinite;
   wdt_len_type period_len;
   wdt_len_type closed_len;
   logic        in_open;
   logic        timeout;
   modport ctl (output restart, output infinite, output period_len, output closed_len,
                input in_open, input timeout);
   modport tmr (input restart, input infinite, input period_len, input closed_len,
                output in_open, output timeout);
endinterface
`default_nettype wire

// ---- hdl/wdt_window_timer.sv ----
`include "wdt_defs.svh"
`default_nettype none
module wdt_window_timer
   import wdt_pkg::*;
#(
   parameter int TICK_CYCLES = 1562
) (
   input  wire logic clk,
   input  wire logic arst_n,
   wdt_tmr_if.tmr    tif
);
   logic [15:0] presc_q, presc_d;
   wdt_len_type elapsed_q, elapsed_d;
   logic        tick;
   logic        at_end;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      tick    = (presc_q == 16'(TICK_CYCLES - 1));
      at_end  = (elapsed_q >= tif.period_len);
      presc_d = tick ? 16'h0000 : presc_q + 16'h0001;
      elapsed_d = elapsed_q;
      if (tick && !at_end) begin
         elapsed_d = elapsed_q + 15'h0001;
      end
      if (tif.restart) begin
         presc_d   = 16'h0000;
         elapsed_d = 15'h0000;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         presc_q   <= 16'h0000;
         elapsed_q <= 15'h0000;
      end else begin
         presc_q   <= presc_d;
         elapsed_q <= elapsed_d;
      end
   end

   // Open once the closed share has elapsed; an infinite window never times out
   assign tif.in_open = tif.infinite || (elapsed_q >= tif.closed_len);
   assign tif.timeout = !tif.infinite && at_end;
endmodule // wdt_window_timer
`default_nettype wire

// ---- sim/wdt_top_chk.sv ----
`default_nettype none
module wdt_top_chk (
   input  wire logic        CLK_SYS,
   input  wire logic        ARST_N,
   input  wire logic        SCHEME_SELECT_FUSE,
   input  wire logic        SEED_WR,
   input  wire logic [3:0]  ERR_COUNT,
   input  wire logic [15:0] SEED_VALUE,
   input  wire logic        TIMING_FAULT_FLAG,
   input  wire logic        ANSWER_FAULT_FLAG,
   input  wire logic        WDOG_ACTIVE,
   input  wire logic        WINDOW_OPEN,
   input  wire logic        GOOD_REFRESH,
   input  wire logic        BAD_REFRESH,
   input  wire logic        WDOG_FAIL
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   ////////////////////////////////////////////////////////////////
   a_bad_adds_two: assert property (BAD_REFRESH && !WDOG_FAIL |->
      ERR_COUNT == $past(ERR_COUNT) + 4'h2) else $error("bad step wrong");
   a_good_subs_one: assert property (GOOD_REFRESH |-> ERR_COUNT ==
      ($past(ERR_COUNT) == 4'h0 ? 4'h0 : $past(ERR_COUNT) - 4'h1)) else $error("good step wrong");
   a_fail_clears: assert property (WDOG_FAIL |-> ERR_COUNT == 4'h0 && BAD_REFRESH)
      else $error("fail without clear");
   a_off_quiet: assert property (!$past(WDOG_ACTIVE) |-> !GOOD_REFRESH && !BAD_REFRESH)
      else $error("judged while off");
   a_data_flag_bad: assert property ($rose(ANSWER_FAULT_FLAG) |-> BAD_REFRESH)
      else $error("answer flag without bad");
   a_time_flag_bad: assert property ($rose(TIMING_FAULT_FLAG) |-> BAD_REFRESH)
      else $error("timing flag without bad");
   a_restart_closed: assert property (GOOD_REFRESH || BAD_REFRESH |->
      !WINDOW_OPEN ##1 !WINDOW_OPEN) else $error("window not restarted");
   a_seed_step: assert property (GOOD_REFRESH && !$past(SEED_WR) |->
      (SEED_VALUE != $past(SEED_VALUE)) == SCHEME_SELECT_FUSE) else $error("seed step wrong");
   a_seed_hold: assert property (BAD_REFRESH && !$past(SEED_WR) |-> $stable(SEED_VALUE))
      else $error("seed moved on bad");
   c_good: cover property (GOOD_REFRESH);
   c_fail: cover property (WDOG_FAIL);
   c_both_flags: cover property (TIMING_FAULT_FLAG && ANSWER_FAULT_FLAG);
endmodule // wdt_top_chk
bind wdt_top wdt_top_chk wdt_top_chk_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
   .SCHEME_SELECT_FUSE(SCHEME_SELECT_FUSE), .SEED_WR(SEED_WR), .ERR_COUNT(ERR_COUNT),
   .SEED_VALUE(SEED_VALUE), .TIMING_FAULT_FLAG(TIMING_FAULT_FLAG),
   .ANSWER_FAULT_FLAG(ANSWER_FAULT_FLAG), .WDOG_ACTIVE(WDOG_ACTIVE),
   .WINDOW_OPEN(WINDOW_OPEN), .GOOD_REFRESH(GOOD_REFRESH), .BAD_REFRESH(BAD_REFRESH),
   .WDOG_FAIL(WDOG_FAIL));
`default_nettype wire

// ---- sim/wdt_mcu_model.sv ----
`default_nettype none
module wdt_mcu_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic        wait_open,
   input  wire logic        wrong,
   input  wire logic        win_open,
   input  wire logic [15:0] seed,
   output logic             ans_wr,
   output logic [15:0]      ans_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pend;
   logic bad;
   logic wo;
   initial begin
      ans_wr = 1'b0;
      ans_data = 16'h0000;
      pend = 1'b0;
   end
   always @(posedge clk) begin
      ans_wr <= 1'b0;
      // Released data must not pass for a stale answer
      if (ans_wr) begin
         ans_data <= ~ans_data;
      end
      if (go) begin
         pend <= 1'b1;
         bad <= wrong;
         wo <= wait_open;
      end else if (pend && (!wo || win_open)) begin
         pend <= 1'b0;
         ans_wr <= 1'b1;
         ans_data <= bad ? ~seed : seed;
      end
   end
endmodule // wdt_mcu_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, arst_n, fdis, fsch, init, cfg_wr, seed_wr, clr_t, clr_a, go, wo, wr;
   logic [3:0]  per, inv, rd_per, rd_inv, err;
   logic [2:0]  duty, rd_duty;
   logic [15:0] seed_d, rd_seed, ans_d;
   logic        ans_wr, tflag, aflag, active, wopen, good, bad, srej, fail;
   int          mismatches, comparisons, cycles, n;
   logic [15:0] s;
   wdt_top #(.MS_CYCLES(16)) wdt_top_inst (.CLK_SYS(clk), .ARST_N(arst_n),
      .WDOG_DISABLE_FUSE(fdis), .SCHEME_SELECT_FUSE(fsch), .INIT_PHASE(init),
      .CFG_WR(cfg_wr), .CFG_PERIOD_CODE(per), .CFG_PERIOD_INV(inv), .CFG_DUTY_CODE(duty),
      .SEED_WR(seed_wr), .SEED_DATA(seed_d), .ANSWER_WR(ans_wr), .ANSWER_DATA(ans_d),
      .FLAG_CLR_TIMING(clr_t), .FLAG_CLR_ANSWER(clr_a), .WINDOW_PERIOD_CODE(rd_per),
      .WINDOW_PERIOD_INVERSE(rd_inv), .WINDOW_DUTY_CODE(rd_duty), .SEED_VALUE(rd_seed),
      .ERR_COUNT(err), .TIMING_FAULT_FLAG(tflag), .ANSWER_FAULT_FLAG(aflag),
      .WDOG_ACTIVE(active), .WINDOW_OPEN(wopen), .GOOD_REFRESH(good), .BAD_REFRESH(bad),
      .SEED_REJECT(srej), .WDOG_FAIL(fail));
   wdt_mcu_model wdt_mcu_model_inst (.clk(clk), .go(go), .wait_open(wo), .wrong(wr),
      .win_open(wopen), .seed(rd_seed), .ans_wr(ans_wr), .ans_data(ans_d));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Both first windows stay closed for 8192 of their 16384 cycles each at this scale
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic rng(input int lo, input int hi);
      chk(16'(n >= lo && n <= hi), 16'h0001);
   endtask
   task automatic do_reset(input logic d, input logic sc);
      @(posedge clk);
      arst_n <= 1'b0;
      fdis <= d;
      fsch <= sc;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Outputs move at the edge itself; look once they have settled
      @(negedge clk);
   endtask
   task automatic ev();
      n = 0;
      @(negedge clk);
      while (!(good || bad) && n < 20000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic meas();
      n = 0;
      while (!wopen && n < 20000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic refresh(input logic w, input logic r);
      @(posedge clk);
      go <= 1'b1;
      wo <= w;
      wr <= r;
      @(posedge clk);
      go <= 1'b0;
      ev();
   endtask
   task automatic cfg(input logic [3:0] p, input logic [3:0] i, input logic [2:0] c);
      @(posedge clk);
      cfg_wr <= 1'b1;
      per <= p;
      inv <= i;
      duty <= c;
      @(posedge clk);
      cfg_wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic seed_w(input logic [15:0] v);
      @(posedge clk);
      seed_wr <= 1'b1;
      seed_d <= v;
      @(posedge clk);
      seed_wr <= 1'b0;
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      do_reset(1'b0, 1'b0);
      chk(16'(rd_per), 16'h0003);
      chk(16'(rd_inv), 16'h000C);
      chk(16'(rd_duty), 16'h0002);
      chk(rd_seed, 16'h5AB2);
      chk(16'(active), 16'h0001);
   endtask
   task automatic t_first();
      meas();
      rng(8185, 8200);
      refresh(1'b1, 1'b0);
      chk(16'(good), 16'h0001);
      chk(16'(err), 16'h0000);
   endtask
   task automatic t_closed();
      refresh(1'b0, 1'b0);
      chk(16'(bad), 16'h0001);
      chk(16'(tflag), 16'h0001);
      chk(16'(err), 16'h0002);
   endtask
   task automatic t_wrong();
      refresh(1'b1, 1'b1);
      chk(16'(bad), 16'h0001);
      chk(16'(aflag), 16'h0001);
      chk(16'(err), 16'h0004);
      chk(rd_seed, 16'h5AB2);
   endtask
   task automatic t_period();
      @(posedge clk);
      clr_t <= 1'b1;
      clr_a <= 1'b1;
      @(posedge clk);
      clr_t <= 1'b0;
      clr_a <= 1'b0;
      @(negedge clk);
      chk(16'({tflag, aflag}), 16'h0000);
      cfg(4'h1, 4'h0, 3'h0);
      refresh(1'b1, 1'b0);
      cfg(4'h1, 4'hE, 3'h0);
      chk(16'(rd_per), 16'h0001);
      meas();
      // Period kept at 3 ms, duty 000 already adopted: 15 closed cycles
      rng(13, 15);
      refresh(1'b1, 1'b0);
      chk(16'(err), 16'h0002);
      meas();
      rng(4, 8);
   endtask
   task automatic t_errs();
      ev();
      chk(16'({bad, tflag}), 16'h0003);
      refresh(1'b1, 1'b1);
      chk(16'(err), 16'h0006);
      refresh(1'b1, 1'b1);
      chk(16'({fail, err}), 16'h0010);
   endtask
   task automatic t_chal();
      init <= 1'b1;
      do_reset(1'b0, 1'b1);
      seed_w(16'h0000);
      chk({srej, rd_seed[14:0]}, 16'hDAB2);
      seed_w(16'h1234);
      chk(rd_seed, 16'h1234);
      refresh(1'b1, 1'b0);
      chk(16'(good), 16'h0001);
      chk(rd_seed, 16'h2469);
      s = rd_seed;
      refresh(1'b1, 1'b1);
      chk(rd_seed, s);
      // Infinite code outside init must be ignored: 3 ms window stays
      init <= 1'b0;
      cfg(4'h0, 4'hF, 3'h2);
      refresh(1'b1, 1'b0);
      chk(16'(good), 16'h0001);
      meas();
      rng(24, 26);
   endtask
   task automatic t_dis();
      do_reset(1'b1, 1'b0);
      repeat (40) @(posedge clk);
      go <= 1'b1;
      wo <= 1'b0;
      @(posedge clk);
      go <= 1'b0;
      repeat (5) @(negedge clk);
      chk(16'({active, tflag, aflag, err}), 16'h0000);
   endtask
   initial begin
      {arst_n, fdis, fsch, init, cfg_wr, seed_wr, clr_t, clr_a, go, wo, wr} = 11'h000;
      {per, inv, duty, seed_d} = 27'h0000000;
      t_reset();
      t_first();
      t_closed();
      t_wrong();
      t_period();
      t_errs();
      t_chal();
      t_dis();
      close_out();
   end
endmodule // tb_top
`default_nettype wire
